/* File: rtl/pifeb_bank.v */
`timescale 1ns/10ps
`include "pifeb_defines.vh"
// How it works
// - comparator change sets flag bit 6 of flags two; software writes zero to clear.
// - nonvolatile write completion sets bit 4; zero while pending or never started.
// - bus collision as i2c master sets bit 3; cleared by software.
// - supply below trip point sets low-voltage bit 2; cleared by software.
// - third timer overflow sets bit 1; cleared by software.
// - capture/compare two event sets bit 0; unused in pwm; software clear only.
// - serial two receive flag is read-only, one while receive buffer full.
// - serial two transmit flag is read-only, one while transmit buffer empty.
// - fourth timer period event sets flags three bit 3; cleared by software.
// - capture/compare three to five set flags three bits 2-0; software cleared.
// - unimplemented bits read zero and ignore writes.
// - with priority levels off, peripheral group enable must be set for requests.
// - enables one holds eight per-source enables, reset to zero.
// - parallel port enable only acts on large variant in microcontroller mode.
// - enables two matches flags two layout, reset to zero.
// - enables three covers serial two, timer four and capture three to five.
// - flags set on their condition regardless of any enable bit.
module pifeb_bank (
   input  wire        pclk,
   input  wire        presetn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // peripheral event pulses, same clock domain
   input  wire        comparator_change_evt,
   input  wire        nv_write_done_evt,
   input  wire        bus_collision_evt,
   input  wire        low_voltage_evt,
   input  wire        timer_three_overflow_evt,
   input  wire        capcmp_two_evt,
   input  wire        timer_four_event_evt,
   input  wire [2:0]  capcmp_three_to_five_evt,
   // serial two buffer levels from the serial port
   input  wire        serial_two_rx_full,
   input  wire        serial_two_tx_empty,
   // first flag register contents, kept by the core side
   input  wire [7:0]  periph_flags_one,
   // requests to the core
   output reg         periph_irq_req,
   output reg         irq
);

   ////////////////////////////////////////////////////////////////////////
   // bus decode

   wire       wr_en = psel & penable & pwrite;
   wire       rd_en = psel & penable & ~pwrite;
   wire [7:0] wb    = pwdata[7:0];

   wire hit_f2  = (paddr == `PIFEB_OFF_FLAGS_TWO);
   wire hit_f3  = (paddr == `PIFEB_OFF_FLAGS_THREE);
   wire hit_e1  = (paddr == `PIFEB_OFF_ENABLES_ONE);
   wire hit_e2  = (paddr == `PIFEB_OFF_ENABLES_TWO);
   wire hit_e3  = (paddr == `PIFEB_OFF_ENABLES_THREE);
   wire hit_ctl = (paddr == `PIFEB_OFF_CONTROL);
   wire hit_st  = (paddr == `PIFEB_OFF_STATUS);
   wire hit_is  = (paddr == `PIFEB_OFF_IRQ_STATUS);
   wire hit_im  = (paddr == `PIFEB_OFF_IRQ_MASK);
   wire hit_any = hit_f2 | hit_f3 | hit_e1 | hit_e2 | hit_e3 | hit_ctl | hit_st | hit_is | hit_im;

   ////////////////////////////////////////////////////////////////////////
   // sticky flags; software clears a bit by writing zero to it

   wire [7:0] set_two;
   wire [7:0] set_three;
   wire [7:0] flags_two;
   wire [7:0] flags_three_sw;
   wire [7:0] clr_two;
   wire [7:0] clr_three;

   // events set flags whatever the enables say, so polling works
   assign set_two = {1'b0, comparator_change_evt, 1'b0, nv_write_done_evt,
                     bus_collision_evt, low_voltage_evt,
                     timer_three_overflow_evt, capcmp_two_evt};
   assign set_three = {4'h0, timer_four_event_evt, capcmp_three_to_five_evt};

   // a written zero on a software-writable bit clears it; ones are ignored
   assign clr_two   = (wr_en & hit_f2) ? (~wb & `PIFEB_MASK_TWO)      : 8'h00;
   assign clr_three = (wr_en & hit_f3) ? (~wb & `PIFEB_MASK_THREE_SW) : 8'h00;

   // one cell per bit; unimplemented positions have no set and no clear
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
         pifeb_flag_cell u_two (
            .pclk      (pclk),
            .presetn   (presetn),
            .set_pulse (set_two[gi]),
            .clr_pulse (clr_two[gi]),
            .flag_r    (flags_two[gi])
         );
         pifeb_flag_cell u_three (
            .pclk      (pclk),
            .presetn   (presetn),
            .set_pulse (set_three[gi]),
            .clr_pulse (clr_three[gi]),
            .flag_r    (flags_three_sw[gi])
         );
      end
   endgenerate

   // serial two flags follow the buffer state, no storage here
   wire [7:0] flags_three;
   assign flags_three = (flags_three_sw & `PIFEB_MASK_THREE_SW) |
                        ({7'h00, serial_two_rx_full} << `PIFEB_BIT_RX2) |
                        ({7'h00, serial_two_tx_empty} << `PIFEB_BIT_TX2);

   wire [7:0] flags_two_rd = flags_two & `PIFEB_MASK_TWO;

   ////////////////////////////////////////////////////////////////////////
   // enable and control registers

   reg [7:0] en_one_r;
   reg [7:0] en_two_r;
   reg [7:0] en_three_r;
   reg [3:0] ctl_r;

   // enables reset to zero; unimplemented bits are masked on write
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_one_r   <= `PIFEB_RST_BYTE;
         en_two_r   <= `PIFEB_RST_BYTE;
         en_three_r <= `PIFEB_RST_BYTE;
         ctl_r      <= `PIFEB_RST_CTL;
      end else if (wr_en) begin
         if (hit_e1) begin
            en_one_r <= wb & `PIFEB_MASK_ONE;
         end
         if (hit_e2) begin
            en_two_r <= wb & `PIFEB_MASK_TWO;
         end
         if (hit_e3) begin
            en_three_r <= wb & `PIFEB_MASK_THREE;
         end
         if (hit_ctl) begin
            ctl_r <= pwdata[3:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // request combine

   wire peripheral_group_enable   = ctl_r[`PIFEB_CTL_PERIPHERAL_GROUP_ENABLE];
   wire priority_levels_enable   = ctl_r[`PIFEB_CTL_PRIORITY_LEVELS_ENABLE];
   // parallel port enable only counts on the large part in mcu mode
   wire psp_ok = ctl_r[`PIFEB_CTL_MCU] & ctl_r[`PIFEB_CTL_BIGPKG];
   wire [7:0] en_one_eff = en_one_r & {psp_ok, 7'h7F};

   wire any_src = (|(periph_flags_one & en_one_eff)) |
                  (|(flags_two_rd & en_two_r)) |
                  (|(flags_three & en_three_r));
   // group enable only matters with priority levels off
   wire req_nxt = any_src & (priority_levels_enable | peripheral_group_enable);

   ////////////////////////////////////////////////////////////////////////
   // interrupt bookkeeping: request rise and bus error events

   reg [1:0] ev_st_r;
   reg [1:0] ev_mask_r;
   reg       req_d_r;
   wire      bad_acc = psel & penable & ~hit_any;
   wire [1:0] ev_set = {bad_acc, req_nxt & ~req_d_r};
   wire [1:0] ev_clr = (wr_en & hit_is) ? pwdata[1:0] : 2'h0;

   // set wins over write-one-to-clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_st_r   <= `PIFEB_RST_EV;
         ev_mask_r <= `PIFEB_RST_EV;
         req_d_r   <= 1'b0;
      end else begin
         ev_st_r <= ev_set | (ev_st_r & ~ev_clr);
         req_d_r <= req_nxt;
         if (wr_en & hit_im) begin
            ev_mask_r <= pwdata[1:0];
         end
      end
   end

   // outputs registered so the core never sees decode glitches
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         periph_irq_req <= 1'b0;
         irq            <= 1'b0;
      end else begin
         periph_irq_req <= req_nxt;
         irq            <= |((ev_set | (ev_st_r & ~ev_clr)) & ev_mask_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // apb read path; zero wait states, error on unmapped addresses

   reg [31:0] rd_nxt;

   always @* begin
      rd_nxt = `PIFEB_RST_WORD;
      case (1'b1)
         hit_f2:  rd_nxt = {24'h0, flags_two_rd};
         hit_f3:  rd_nxt = {24'h0, flags_three};
         hit_e1:  rd_nxt = {24'h0, en_one_r};
         hit_e2:  rd_nxt = {24'h0, en_two_r};
         hit_e3:  rd_nxt = {24'h0, en_three_r};
         hit_ctl: rd_nxt = {28'h0, ctl_r};
         hit_st:  rd_nxt = {31'h0, req_nxt};
         hit_is:  rd_nxt = {30'h0, ev_st_r};
         hit_im:  rd_nxt = {30'h0, ev_mask_r};
         default: rd_nxt = `PIFEB_RST_WORD;
      endcase
   end

   // answer registered in the setup cycle so pready is high at the access edge
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= `PIFEB_RST_WORD;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~hit_any;
         prdata  <= (psel & ~penable & ~pwrite) ? rd_nxt : `PIFEB_RST_WORD;
      end
   end

   // rd_en kept for clarity of the read strobe; reads have no side effect here
   wire unused_rd = rd_en;

endmodule

/* File: rtl/pifeb_defines.vh */
`ifndef PIFEB_DEFINES_VH
`define PIFEB_DEFINES_VH

// register byte offsets on the apb bus
`define PIFEB_OFF_FLAGS_TWO     12'h000
`define PIFEB_OFF_FLAGS_THREE   12'h004
`define PIFEB_OFF_ENABLES_ONE   12'h008
`define PIFEB_OFF_ENABLES_TWO   12'h00C
`define PIFEB_OFF_ENABLES_THREE 12'h010
`define PIFEB_OFF_CONTROL       12'h014
`define PIFEB_OFF_STATUS        12'h018
`define PIFEB_OFF_IRQ_STATUS    12'h01C
`define PIFEB_OFF_IRQ_MASK      12'h020

// implemented-bit masks; unimplemented bits read zero and ignore writes
`define PIFEB_MASK_TWO          8'h5F
`define PIFEB_MASK_THREE        8'h3F
`define PIFEB_MASK_ONE          8'hFF
// software-writable bits of the third flag register (serial bits are read-only)
`define PIFEB_MASK_THREE_SW     8'h0F

// field positions
`define PIFEB_BIT_CMP           6
`define PIFEB_BIT_NVW           4
`define PIFEB_BIT_BCOL          3
`define PIFEB_BIT_LVD           2
`define PIFEB_BIT_TMR3          1
`define PIFEB_BIT_CCP2          0
`define PIFEB_BIT_RX2           5
`define PIFEB_BIT_TX2           4
`define PIFEB_BIT_PSP           7
`define PIFEB_CTL_PERIPHERAL_GROUP_ENABLE          0
`define PIFEB_CTL_PRIORITY_LEVELS_ENABLE          1
`define PIFEB_CTL_MCU           2
`define PIFEB_CTL_BIGPKG        3
`define PIFEB_EV_REQ            0
`define PIFEB_EV_ACC            1

// reset values
`define PIFEB_RST_BYTE          8'h00
`define PIFEB_RST_WORD          32'h0000_0000
`define PIFEB_RST_CTL           4'h0
`define PIFEB_RST_EV            2'h0

`endif

/* File: rtl/pifeb_flag_cell.v */
`timescale 1ns/10ps
// one sticky flag: hardware set wins over a software clear in the same cycle
module pifeb_flag_cell (
   input  wire pclk,
   input  wire presetn,
   input  wire set_pulse,
   input  wire clr_pulse,
   output reg  flag_r
);

   // set has priority so an event at the clear edge is never lost
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_r <= 1'b0;
      end else if (set_pulse) begin
         flag_r <= 1'b1;
      end else if (clr_pulse) begin
         flag_r <= 1'b0;
      end
   end

endmodule

/* File: verification/pifeb_bank_monitor.sv */
`timescale 1ns/10ps
// port-level watch on the apb slave and the live serial flags
module pifeb_bank_monitor (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        serial_two_rx_full,
   input wire        serial_two_tx_empty
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////
   // zero wait states: the access cycle always answers
   a_ready_next: assert property (psel && !penable |=> pready && penable) else $error("pready late");
   a_ready_access: assert property (pready |-> psel && penable) else $error("pready outside access");
   a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
   a_unmapped_err: assert property (pready && (paddr > 12'h020 || paddr[1:0] != 2'b00)
      |-> pslverr && (pwrite || prdata == 32'h0000_0000)) else $error("unmapped access not refused");
   a_mapped_ok: assert property (pready && paddr <= 12'h020 && paddr[1:0] == 2'b00 |-> !pslverr)
      else $error("mapped access refused");
   // unimplemented bits never read back as one
   a_two_unused: assert property (pready && !pwrite && (paddr == 12'h000 || paddr == 12'h00C)
      |-> (prdata & 32'hFFFF_FFA0) == 32'h0000_0000) else $error("unused bit set in layout two");
   a_three_unused: assert property (pready && !pwrite && (paddr == 12'h004 || paddr == 12'h010)
      |-> (prdata & 32'hFFFF_FFC0) == 32'h0000_0000) else $error("unused bit set in layout three");
   // levels held steady for two cycles must show through unchanged
   a_rx_live: assert property (pready && !pwrite && paddr == 12'h004 && $stable(serial_two_rx_full)
      && $past(serial_two_rx_full, 2) == serial_two_rx_full |-> prdata[5] == serial_two_rx_full)
      else $error("receive flag not live");
   a_tx_live: assert property (pready && !pwrite && paddr == 12'h004 && $stable(serial_two_tx_empty)
      && $past(serial_two_tx_empty, 2) == serial_two_tx_empty |-> prdata[4] == serial_two_tx_empty)
      else $error("transmit flag not live");
endmodule

bind pifeb_bank pifeb_bank_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .serial_two_rx_full(serial_two_rx_full), .serial_two_tx_empty(serial_two_tx_empty));

/* File: verification/pifeb_periph_model.sv */
`timescale 1ns/10ps
// peripherals: a toggle on trig gives a one-cycle event; buf_op moves the buffers
module pifeb_periph_model (
   input  wire       pclk,
   input  wire       presetn,
   input  wire [9:0] trig,
   input  wire [3:0] buf_op,
   output reg  [9:0] evt_r,
   output reg        rx_full_r,
   output reg        tx_empty_r
);
   reg [9:0] last_r;
   ////////////////////////////////////////////////////////////////
   // edge detect so the bench never has to drop a pulse itself
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_r <= 10'h000;
         last_r <= 10'h000;
         rx_full_r <= 1'b0;
         tx_empty_r <= 1'b1;
      end else begin
         evt_r <= trig ^ last_r;
         last_r <= trig;
         rx_full_r <= (rx_full_r | buf_op[0]) & ~buf_op[1];
         tx_empty_r <= (tx_empty_r | buf_op[3]) & ~buf_op[2];
      end
   end
endmodule

/* File: verification/testbench.sv */
`timescale 1ns/10ps
module testbench;
   reg         pclk = 1'b0;
   reg         presetn = 1'b0;
   reg         psel = 1'b0;
   reg         penable = 1'b0;
   reg         pwrite = 1'b0;
   reg  [11:0] paddr = 12'h000;
   reg  [31:0] pwdata = 32'h0000_0000;
   reg  [9:0]  trig = 10'h000;
   reg  [3:0]  buf_op = 4'h0;
   reg  [7:0]  flags_one = 8'h00;
   reg  [31:0] q;
   reg  [31:0] d;
   reg  [31:0] base;
   reg  [11:0] a;
   reg         err;
   wire [31:0] prdata;
   wire        pready;
   wire        pslverr;
   wire        irq;
   wire        req;
   wire        rx_full;
   wire        tx_empty;
   wire [9:0]  evt;
   int         num_errors = 0;
   int         num_checks = 0;
   int         bpos [10] = '{6, 4, 3, 2, 1, 0, 3, 0, 1, 2};

   pifeb_periph_model u_per (.pclk(pclk), .presetn(presetn), .trig(trig), .buf_op(buf_op), .evt_r(evt),
      .rx_full_r(rx_full), .tx_empty_r(tx_empty));
   pifeb_bank DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .comparator_change_evt(evt[0]), .nv_write_done_evt(evt[1]), .bus_collision_evt(evt[2]),
      .low_voltage_evt(evt[3]), .timer_three_overflow_evt(evt[4]), .capcmp_two_evt(evt[5]),
      .timer_four_event_evt(evt[6]), .capcmp_three_to_five_evt(evt[9:7]), .serial_two_rx_full(rx_full),
      .serial_two_tx_empty(tx_empty), .periph_flags_one(flags_one), .periph_irq_req(req), .irq(irq));

   // 40 mhz
   initial forever #12.5 pclk = ~pclk;
   ////////////////////////////////////////////////////////////////
   task chk(input [31:0] seen, input [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // one apb transfer; the wait is bounded so a stuck slave ends the run
   task apb(input w, input [11:0] ad, input [31:0] wd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 16) begin
         num_errors++;
         print_verdict;
      end
   endtask
   task wr(input [11:0] ad, input [31:0] wd);
      apb(1'b1, ad, wd);
   endtask
   task rd(input [11:0] ad, input [31:0] exp);
      apb(1'b0, ad, 32'h0000_0000);
      chk(q, exp);
   endtask
   task tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task fire(input int i);
      @(posedge pclk);
      trig <= trig ^ (10'h001 << i);
      tick(3);
   endtask
   task op(input [3:0] o);
      @(posedge pclk);
      buf_op <= o;
      @(posedge pclk);
      buf_op <= 4'h0;
      tick(2);
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'he4861ed3));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 6; i++) rd(12'(4 * i), i == 1 ? 32'h10 : 32'h0);
      $display("test reset done");
      wr(12'h000, 32'hFF);
      rd(12'h000, 32'h0);
      // enables stay off, so each flag shows it is set by the event alone
      for (int i = 0; i < 10; i++) begin
         fire(i);
         a = i < 6 ? 12'h000 : 12'h004;
         base = i < 6 ? 32'h0 : 32'h10;
         rd(a, base | (32'h1 << bpos[i]));
         wr(a, 32'hFF ^ (32'h1 << bpos[i]));
         rd(a, base);
      end
      $display("test flags done");
      for (int i = 0; i < 6; i++) begin
         a = 12'h008 + 12'(4 * (i % 3));
         d = $urandom;
         wr(a, d);
         rd(a, d & (i % 3 == 0 ? 32'hFF : i % 3 == 1 ? 32'h5F : 32'h3F));
      end
      wr(12'h008, 32'h0);
      wr(12'h010, 32'h0);
      $display("test enables done");
      op(4'b0101);
      rd(12'h004, 32'h20);
      wr(12'h004, 32'h0);
      rd(12'h004, 32'h20);
      op(4'b1010);
      rd(12'h004, 32'h10);
      $display("test serial done");
      wr(12'h00C, 32'h40);
      wr(12'h014, 32'h0);
      fire(0);
      chk(req, 32'h0);
      wr(12'h014, 32'h1);
      tick(3);
      chk(req, 32'h1);
      rd(12'h018, 32'h1);
      wr(12'h014, 32'h2);
      tick(3);
      chk(req, 32'h1);
      // software clears the serviced flag so no stale request remains
      wr(12'h000, 32'h0);
      tick(3);
      chk(req, 32'h0);
      rd(12'h018, 32'h0);
      $display("test request done");
      // status is sticky, mask gates the level, a one written clears
      rd(12'h01C, 32'h1);
      chk(irq, 32'h0);
      wr(12'h020, 32'h1);
      tick(2);
      chk(irq, 32'h1);
      wr(12'h01C, 32'h1);
      tick(2);
      chk(irq, 32'h0);
      rd(12'h01C, 32'h0);
      apb(1'b0, 12'h040, 32'h0);
      chk(err, 32'h1);
      chk(q, 32'h0);
      wr(12'h020, 32'h2);
      tick(2);
      chk(irq, 32'h1);
      wr(12'h01C, 32'h2);
      tick(2);
      chk(irq, 32'h0);
      $display("test interrupt done");
      wr(12'h00C, 32'h0);
      wr(12'h008, 32'h80);
      wr(12'h014, 32'h1);
      flags_one <= 8'h80;
      tick(3);
      chk(req, 32'h0);
      wr(12'h014, 32'hD);
      tick(3);
      chk(req, 32'h1);
      $display("test parallel port done");
      print_verdict;
   end
endmodule
